// ==== rtl/pcr_pkg.sv ====
// package: constants, types and strap encodings for the power-up clock ratio block
// How it works
// R1 - platform ratio from reference clock and straps
// R2 - board must drive platform straps, no default
// R3 - core1 ratio from three core1 straps
// R4 - core1 codes 000-010 reserved, rest decoded
// R5 - memory code gives DDR rate multiple
// R6 - memory code 111 selects synchronous mode
// R7 - sync mode: memory clock half platform
// R8 - memory bus clock half DDR rate
// R9 - async: DDR rate is multiple times ref
// R10 - memory ref clock needed only when async
// R11 - one sync/async choice for both controllers
// R12 - async: mem clock <= platform < DDR
// R13 - memory bus clock 200 to 400 MHz
// R14 - ratios keep frequencies within limits
// R15 - straps latched once at reset release
package pcr_pkg;
  localparam int CLK_MHZ = 40;
  localparam int CORE_RATIO_BITS = 5;
  // core1 ratio in half steps: 3 = 1.5:1
  localparam logic [4:0] CORE_HALF_RSVD = 5'h00;
  localparam logic [4:0] CORE_HALF_3_2 = 5'h03;
  localparam logic [4:0] CORE_HALF_2_1 = 5'h04;
  localparam logic [4:0] CORE_HALF_5_2 = 5'h05;
  localparam logic [4:0] CORE_HALF_3_1 = 5'h06;
  localparam logic [4:0] CORE_HALF_7_2 = 5'h07;
  localparam logic [2:0] MEM_CODE_SYNC = 3'h7;
  localparam logic [4:0] MEM_MULT_SYNC = 5'h00;

  // AXI4-Lite register map
  localparam logic [7:0] REG_STRAPS = 8'h00;
  localparam logic [7:0] REG_RATIOS = 8'h04;
  localparam logic [7:0] REG_MEMCFG = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] platform;
    logic [2:0] core1;
    logic [2:0] mem;
  } pcr_straps_t;

  typedef struct packed {
    logic [2:0] platform_ratio_code;
    logic [4:0] core1_half_ratio;
    logic core1_reserved;
    logic [4:0] ddr_mult;
    logic mem_sync;
  } pcr_ratios_t;
endpackage

// ==== rtl/pcr_decode.sv ====
// strap decoder: turns latched strap codes into ratio fields
module pcr_decode (
  input wire pcr_pkg::pcr_straps_t straps,
  output pcr_pkg::pcr_ratios_t ratios
);
  always_comb begin
    ratios = '0;
    ratios.platform_ratio_code = straps.platform; // [R1]
    unique case (straps.core1) // [R3] [R4]
      3'h3: ratios.core1_half_ratio = pcr_pkg::CORE_HALF_3_2;
      3'h4: ratios.core1_half_ratio = pcr_pkg::CORE_HALF_2_1;
      3'h5: ratios.core1_half_ratio = pcr_pkg::CORE_HALF_5_2;
      3'h6: ratios.core1_half_ratio = pcr_pkg::CORE_HALF_3_1;
      3'h7: ratios.core1_half_ratio = pcr_pkg::CORE_HALF_7_2;
      default: begin
        ratios.core1_half_ratio = pcr_pkg::CORE_HALF_RSVD;
        ratios.core1_reserved = 1'b1;
      end
    endcase
    unique case (straps.mem) // [R5]
      3'h0: ratios.ddr_mult = 5'h03;
      3'h1: ratios.ddr_mult = 5'h04;
      3'h2: ratios.ddr_mult = 5'h06;
      3'h3: ratios.ddr_mult = 5'h08;
      3'h4: ratios.ddr_mult = 5'h0A;
      3'h5: ratios.ddr_mult = 5'h0C;
      3'h6: ratios.ddr_mult = 5'h0E;
      3'h7: ratios.ddr_mult = pcr_pkg::MEM_MULT_SYNC;
    endcase
    ratios.mem_sync = (straps.mem == pcr_pkg::MEM_CODE_SYNC); // [R6] [R11]
  end
endmodule

// ==== rtl/pcr_top.sv ====
// top: strap capture, ratio outputs, memory clock divider, AXI4-Lite slave
module pcr_top (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [2:0] PLATFORM_RATIO_STRAPS,
  input wire logic CORE1_RATIO_STRAP_MSB,
  input wire logic CORE1_RATIO_STRAP_MID,
  input wire logic CORE1_RATIO_STRAP_LSB,
  input wire logic MEM_RATIO_STRAP_MSB,
  input wire logic MEM_RATIO_STRAP_MID,
  input wire logic MEM_RATIO_STRAP_LSB,
  input wire logic PLATFORM_CLOCK_EN,
  input wire logic DDR_RATE_EN,
  output logic STRAPS_VALID,
  output logic [2:0] PLATFORM_RATIO_CODE,
  output logic [4:0] CORE1_HALF_RATIO,
  output logic CORE1_RATIO_RESERVED,
  output logic [4:0] DDR_MULT,
  output logic MEM_SYNC_MODE,
  output logic MEM_PLL_REF_USED,
  output logic MEMORY_BUS_CLOCK_OUT,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // synchronisers for strap pins and rate enables
  logic [10:0] sync1_r, sync2_r;
  logic [10:0] pins;
  assign pins = {PLATFORM_RATIO_STRAPS, CORE1_RATIO_STRAP_MSB, CORE1_RATIO_STRAP_MID,
                 CORE1_RATIO_STRAP_LSB, MEM_RATIO_STRAP_MSB, MEM_RATIO_STRAP_MID,
                 MEM_RATIO_STRAP_LSB, PLATFORM_CLOCK_EN, DDR_RATE_EN};
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  // capture: first cycles after release fill the synchroniser, then latch once
  logic [1:0] cap_cnt_r, cap_cnt_nxt;
  logic valid_r, valid_nxt;
  pcr_pkg::pcr_straps_t straps_r, straps_nxt;
  always_comb begin
    cap_cnt_nxt = cap_cnt_r;
    valid_nxt = valid_r;
    straps_nxt = straps_r;
    if (!valid_r) begin
      if (cap_cnt_r == 2'h2) begin
        straps_nxt = sync2_r[10:2]; // [R15]
        valid_nxt = 1'b1;
      end else begin
        cap_cnt_nxt = cap_cnt_r + 2'h1;
      end
    end
  end
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      cap_cnt_r <= '0;
      valid_r <= 1'b0;
      straps_r <= '0;
    end else begin
      cap_cnt_r <= cap_cnt_nxt;
      valid_r <= valid_nxt;
      straps_r <= straps_nxt;
    end
  end

  pcr_pkg::pcr_ratios_t ratios;
  pcr_decode u_dec (
    .straps(straps_r),
    .ratios(ratios)
  );

  // memory bus clock: toggles on each DDR-rate tick, so half the DDR rate
  logic ctrl_en_r, ctrl_en_nxt;
  logic mck_r, mck_nxt;
  logic tick;
  always_comb begin
    // sync: DDR rate equals platform rate [R7] ; async: PLL-derived rate [R9]
    tick = ratios.mem_sync ? sync2_r[1] : sync2_r[0];
    mck_nxt = mck_r;
    if (valid_r && ctrl_en_r && tick) begin
      mck_nxt = ~mck_r; // [R8]
    end
  end
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      mck_r <= 1'b0;
    end else begin
      mck_r <= mck_nxt;
    end
  end

  // output registers
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      STRAPS_VALID <= 1'b0;
      PLATFORM_RATIO_CODE <= '0;
      CORE1_HALF_RATIO <= '0;
      CORE1_RATIO_RESERVED <= 1'b0;
      DDR_MULT <= '0;
      MEM_SYNC_MODE <= 1'b0;
      MEM_PLL_REF_USED <= 1'b0;
      MEMORY_BUS_CLOCK_OUT <= 1'b0;
    end else begin
      STRAPS_VALID <= valid_r;
      PLATFORM_RATIO_CODE <= ratios.platform_ratio_code; // [R1]
      CORE1_HALF_RATIO <= ratios.core1_half_ratio; // [R3]
      CORE1_RATIO_RESERVED <= ratios.core1_reserved; // [R4]
      DDR_MULT <= ratios.ddr_mult; // [R5]
      MEM_SYNC_MODE <= ratios.mem_sync; // [R6] [R11]
      MEM_PLL_REF_USED <= valid_r & ~ratios.mem_sync; // [R10]
      MEMORY_BUS_CLOCK_OUT <= mck_r;
    end
  end

  // AXI4-Lite slave
  logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    bv_nxt = bv_r;
    rv_nxt = rv_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    br_nxt = br_r;
    rr_nxt = rr_r;
    ctrl_en_nxt = ctrl_en_r;
    // capture only on a real handshake, so a held valid is never taken twice
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_nxt = 1'b1;
      awa_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_nxt = 1'b1;
      wd_nxt = S_AXI_WDATA;
    end
    if (aw_r && w_r) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = pcr_pkg::RESP_OKAY;
      unique case (awa_r)
        pcr_pkg::REG_CTRL: ctrl_en_nxt = wd_r[0];
        pcr_pkg::REG_STRAPS, pcr_pkg::REG_RATIOS, pcr_pkg::REG_MEMCFG: ;
        default: br_nxt = pcr_pkg::RESP_SLVERR;
      endcase
    end
    if (bv_r && S_AXI_BREADY) begin
      bv_nxt = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rv_nxt = 1'b1;
      rr_nxt = pcr_pkg::RESP_OKAY;
      unique case (S_AXI_ARADDR)
        pcr_pkg::REG_STRAPS: rd_nxt = {valid_r, 22'h0, straps_r};
        pcr_pkg::REG_RATIOS: rd_nxt = {19'h0, ratios.core1_reserved,
                                       ratios.core1_half_ratio, 4'h0,
                                       ratios.platform_ratio_code};
        pcr_pkg::REG_MEMCFG: rd_nxt = {26'h0, ratios.mem_sync, ratios.ddr_mult};
        pcr_pkg::REG_CTRL: rd_nxt = {31'h0, ctrl_en_r};
        default: begin
          rd_nxt = 32'h00000000;
          rr_nxt = pcr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_r && S_AXI_RREADY) begin
      rv_nxt = 1'b0;
    end
  end
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      bv_r <= 1'b0;
      rv_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      rd_r <= '0;
      br_r <= '0;
      rr_r <= '0;
      ctrl_en_r <= pcr_pkg::CTRL_RESET[0];
    end else begin
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      bv_r <= bv_nxt;
      rv_r <= rv_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      br_r <= br_nxt;
      rr_r <= rr_nxt;
      ctrl_en_r <= ctrl_en_nxt;
    end
  end
  // ready is a registered "not yet holding" flag
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_ARREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_nxt && !bv_nxt;
      S_AXI_WREADY <= !w_nxt && !bv_nxt;
      S_AXI_ARREADY <= !rv_nxt;
    end
  end
  assign S_AXI_BVALID = bv_r;
  assign S_AXI_BRESP = br_r;
  assign S_AXI_RVALID = rv_r;
  assign S_AXI_RDATA = rd_r;
  assign S_AXI_RRESP = rr_r;
endmodule

// ==== verif/pcr_monitor.sv ====
// checker: strap decode, hold and memory clock relations at the top ports
module pcr_monitor (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic PLATFORM_CLOCK_EN,
  input wire logic DDR_RATE_EN,
  input wire logic STRAPS_VALID,
  input wire logic [2:0] PLATFORM_RATIO_CODE,
  input wire logic [4:0] CORE1_HALF_RATIO,
  input wire logic CORE1_RATIO_RESERVED,
  input wire logic [4:0] DDR_MULT,
  input wire logic MEM_SYNC_MODE,
  input wire logic MEM_PLL_REF_USED,
  input wire logic MEMORY_BUS_CLOCK_OUT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  // tick that the memory clock must follow
  wire logic tick = MEM_SYNC_MODE ? PLATFORM_CLOCK_EN : DDR_RATE_EN;
  core_ratio_a: assert property (STRAPS_VALID |->
    CORE1_RATIO_RESERVED == (CORE1_HALF_RATIO < 5'h03)) else $error("core1 ratio decode");
  mem_mult_a: assert property (STRAPS_VALID && !MEM_SYNC_MODE |->
    DDR_MULT inside {5'h03, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E}) else $error("ddr mult");
  sync_mult_a: assert property (MEM_SYNC_MODE |->
    STRAPS_VALID && DDR_MULT == 5'h00) else $error("sync mode mult");
  ref_use_a: assert property (MEM_PLL_REF_USED ==
    (STRAPS_VALID && !MEM_SYNC_MODE)) else $error("pll ref use");
  ratio_hold_a: assert property (STRAPS_VALID |=> STRAPS_VALID &&
    $stable({PLATFORM_RATIO_CODE, CORE1_HALF_RATIO, DDR_MULT})) else $error("ratios moved");
  latch_time_a: assert property ($rose(RESET_N) |->
    ##[1:5] STRAPS_VALID) else $error("straps not latched");
  clk_tick_a: assert property ($changed(MEMORY_BUS_CLOCK_OUT) |->
    $past(tick, 3) || $past(tick, 4) || $past(tick, 5)) else $error("clock without tick");
  clk_idle_a: assert property (!STRAPS_VALID |->
    !MEMORY_BUS_CLOCK_OUT) else $error("clock before latch");
  cover property (MEM_SYNC_MODE && $changed(MEMORY_BUS_CLOCK_OUT));
  cover property (MEM_PLL_REF_USED && $changed(MEMORY_BUS_CLOCK_OUT));
  cover property (STRAPS_VALID && CORE1_RATIO_RESERVED);
endmodule

// ==== verif/pcr_board.sv ====
// board model: strap resistors and reference tick sources
module pcr_board (
  input wire logic clk,
  input wire logic [8:0] code,
  output logic [2:0] plat,
  output logic [2:0] core1,
  output logic [2:0] mem,
  output logic plat_tick,
  output logic ddr_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  assign {plat, core1, mem} = code;
  // scaled rates: bus clock 1/12 <= platform 1/8 < DDR 1/6
  assign plat_tick = (n % 8) == 0;
  assign ddr_tick = (mem != 3'h7) && (n % 6) == 0;
  always @(posedge clk) n <= (n + 1) % 24;
endmodule

// ==== verif/tb_powerup_clock_ratio_straps.sv ====
// testbench: strap decode, memory clock and register access
module tb_powerup_clock_ratio_straps;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 1'b0;
  logic RESET_N = 1'b0;
  wire logic [2:0] PLATFORM_RATIO_STRAPS;
  wire logic CORE1_RATIO_STRAP_MSB, CORE1_RATIO_STRAP_MID, CORE1_RATIO_STRAP_LSB;
  wire logic MEM_RATIO_STRAP_MSB, MEM_RATIO_STRAP_MID, MEM_RATIO_STRAP_LSB;
  wire logic PLATFORM_CLOCK_EN, DDR_RATE_EN;
  logic STRAPS_VALID, CORE1_RATIO_RESERVED, MEM_SYNC_MODE, MEM_PLL_REF_USED;
  logic MEMORY_BUS_CLOCK_OUT;
  logic [2:0] PLATFORM_RATIO_CODE;
  logic [4:0] CORE1_HALF_RATIO, DDR_MULT;
  logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr;
  logic [8:0] code = 9'h000;
  logic [4:0] mt [8] = '{5'h03, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h00};
  logic p;
  int fail_count = 0, samples_checked = 0, t;
  always #12.5 CLK_SYS = ~CLK_SYS;
  pcr_board i_board (
    .clk(CLK_SYS),
    .code(code),
    .plat(PLATFORM_RATIO_STRAPS),
    .core1({CORE1_RATIO_STRAP_MSB, CORE1_RATIO_STRAP_MID, CORE1_RATIO_STRAP_LSB}),
    .mem({MEM_RATIO_STRAP_MSB, MEM_RATIO_STRAP_MID, MEM_RATIO_STRAP_LSB}),
    .plat_tick(PLATFORM_CLOCK_EN),
    .ddr_tick(DDR_RATE_EN)
  );
  pcr_top i_dut (.*);
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    rr = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    rd = S_AXI_RDATA;
    rr = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge CLK_SYS);
    for (int i = 0; i < 8; i++) begin
      RESET_N <= 1'b0;
      code <= {3'(i), 3'(i), 3'(7 - i)};
      repeat (2) @(posedge CLK_SYS);
      RESET_N <= 1'b1;
      repeat (6) @(posedge CLK_SYS);
      chk("platform", i, PLATFORM_RATIO_CODE);
      chk("core1", (i < 3) ? 0 : i, CORE1_HALF_RATIO);
      chk("reserved", i < 3, CORE1_RATIO_RESERVED);
      chk("mult", mt[7 - i], DDR_MULT);
      chk("sync", i == 0, MEM_SYNC_MODE);
      rdr(8'h08);
      chk("memcfg", {(i == 0), mt[7 - i]}, rd);
      rdr(8'h00);
      chk("straps reg", {1'b1, 22'h0, 3'(i), 3'(i), 3'(7 - i)}, rd);
      rdr(8'h04);
      chk("ratios reg", {19'h0, (i < 3), 5'((i < 3) ? 0 : i), 4'h0, 3'(i)}, rd);
      rdr(8'h0C);
      chk("ctrl", 0, rd);
      chk("mck idle", 0, MEMORY_BUS_CLOCK_OUT);
      wr(8'h0C, 32'h1);
      chk("ctrl bresp", 2'h0, rr);
      rdr(8'h0C);
      chk("ctrl back", 1, rd);
      repeat (10) @(posedge CLK_SYS);
      t = 0;
      p = MEMORY_BUS_CLOCK_OUT;
      repeat (96) begin
        @(posedge CLK_SYS);
        if (MEMORY_BUS_CLOCK_OUT !== p) t++;
        p = MEMORY_BUS_CLOCK_OUT;
      end
      chk("toggles", (i == 0) ? 12 : 16, t);
      code <= ~code;
      repeat (8) @(posedge CLK_SYS);
      chk("held", mt[7 - i], DDR_MULT);
    end
    rdr(8'h10);
    chk("rresp", 2'h2, rr);
    wr(8'h10, 32'h0);
    chk("bresp", 2'h2, rr);
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge CLK_SYS);
    fail_count++;
    stop_test;
  end
endmodule
bind pcr_top pcr_monitor i_mon (.*);
